// >>> hdl/rscs_sideband_ctrl.v
/*
 * Receiver sideband control: hot-plug output, cable detect, sideband status,
 * field identity, CPU and protection interrupts, per-domain reset outputs.
 * Assumes a plain register port on clk, and that each stream or pixel
 * reset is held until its clock is stable.
 */
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "rscs_consts.vh"

module rscs_sideband_ctrl #(
	parameter HPD_ACTIVE_LOW = 0,
	parameter CABLE_ACTIVE_LOW = 0,
	parameter PROTECTION_PRESENT = 1,
	parameter STREAM_VIDEO = 1,
	parameter MS_CYCLES = `RSCS_MS_NS / `RSCS_CLK_PERIOD_NS
) (
	input wire clk,
	input wire nrst,
	input wire pixelClk,
	input wire videoStreamClk,
	input wire videoStreamRstN,
	input wire audioStreamClk,
	input wire audioStreamRstN,
	input wire [`RSCS_ADDR_W-1:0] regAddr,
	input wire [`RSCS_DATA_W-1:0] regWrData,
	input wire regWrStb,
	input wire regRdStb,
	output reg [`RSCS_DATA_W-1:0] regRdData,
	output reg hotplugPin,
	input wire cableDetectPin,
	input wire [`RSCS_SB_W-1:0] sideband_status_word,
	input wire sideband_status_valid,
	input wire videoInterlaced,
	input wire videoFieldOdd,
	output wire fieldId,
	input wire protEngineEvent,
	input wire protTimerEvent,
	output wire irq,
	output wire protection_engine_interrupt,
	output wire protection_timer_interrupt,
	output wire pixelReset,
	output wire videoStreamReset,
	output wire audioStreamReset
);

	localparam [17:0] MS_LAST = MS_CYCLES[17:0] - 18'h00001;
	localparam [`RSCS_PULSE_W-1:0] SHORT_MIN = `RSCS_PULSE_SHORT_MIN_MS;
	localparam [`RSCS_PULSE_W-1:0] SHORT_MAX = `RSCS_PULSE_SHORT_MAX_MS;
	localparam [`RSCS_PULSE_W-1:0] LONG_MS = `RSCS_PULSE_LONG_MS;
	localparam [0:0] HPD_LOW = (HPD_ACTIVE_LOW != 0);
	localparam [0:0] CABLE_LOW = (CABLE_ACTIVE_LOW != 0);

	// ------------------------------------------------------------------------
	// Reset distribution
	// ------------------------------------------------------------------------
	// The control reset reaches every domain; each stream reset only its own.
	wire pixelRstN;
	wire videoRstN;
	wire audioRstN;
	wire videoCombN;
	wire audioCombN;

	assign videoCombN = nrst & videoStreamRstN;
	assign audioCombN = nrst & audioStreamRstN;

	rscs_sync3 #(.W(1), .RESET_VAL(1'b0)) pixelRstSync (
		.clk(pixelClk),
		.nrst(nrst),
		.d(1'b1),
		.q(pixelRstN)
	);

	rscs_sync3 #(.W(1), .RESET_VAL(1'b0)) videoRstSync (
		.clk(videoStreamClk),
		.nrst(videoCombN),
		.d(1'b1),
		.q(videoRstN)
	);

	rscs_sync3 #(.W(1), .RESET_VAL(1'b0)) audioRstSync (
		.clk(audioStreamClk),
		.nrst(audioCombN),
		.d(1'b1),
		.q(audioRstN)
	);

	assign pixelReset = ~pixelRstN;
	assign videoStreamReset = ~videoRstN;
	assign audioStreamReset = ~audioRstN;

	// ------------------------------------------------------------------------
	// Field identity
	// ------------------------------------------------------------------------
	reg pixelField_reg;
	wire streamField;

	always @(posedge pixelClk or negedge pixelRstN) begin
		if (!pixelRstN) begin
			pixelField_reg <= 1'b0;
		end else begin
			pixelField_reg <= videoInterlaced & videoFieldOdd;
		end
	end

	// The bridge carries the pixel-clock field flag into the stream clock.
	rscs_sync3 #(.W(1), .RESET_VAL(1'b0)) fieldBridge (
		.clk(videoStreamClk),
		.nrst(videoRstN),
		.d(pixelField_reg),
		.q(streamField)
	);

	assign fieldId = (STREAM_VIDEO != 0) ? streamField : pixelField_reg;

	// ------------------------------------------------------------------------
	// Pin inputs
	// ------------------------------------------------------------------------
	wire cableSync;
	wire [`RSCS_SB_W:0] sbSync;
	wire cableDetected;
	reg linkReady_reg;
	reg videoReady_reg;

	rscs_sync3 #(.W(1), .RESET_VAL(CABLE_LOW)) cableFilter (
		.clk(clk),
		.nrst(nrst),
		.d(cableDetectPin),
		.q(cableSync)
	);

	rscs_sync3 #(.W(`RSCS_SB_W + 1), .RESET_VAL(3'h0)) sidebandFilter (
		.clk(clk),
		.nrst(nrst),
		.d({sideband_status_valid, sideband_status_word}),
		.q(sbSync)
	);

	assign cableDetected = cableSync ^ CABLE_LOW;

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			linkReady_reg <= 1'b0;
			videoReady_reg <= 1'b0;
		end else if (sbSync[`RSCS_SB_W]) begin
			linkReady_reg <= sbSync[`RSCS_SB_LINK_READY];
			videoReady_reg <= sbSync[`RSCS_SB_VIDEO_READY];
		end
	end

	// ------------------------------------------------------------------------
	// Hot-plug and timed release pulse
	// ------------------------------------------------------------------------
	reg hotplugCmd_reg;
	reg pulseBusy_reg;
	reg [17:0] msCount_reg;
	reg [`RSCS_PULSE_W-1:0] pulseLeft_reg;
	reg [`RSCS_PULSE_W-1:0] pulseLen_reg;
	wire ctrlWr;
	wire pulseWr;
	wire msTick;
	wire pulseDone;
	wire hotplugLevel;

	assign ctrlWr = regWrStb && (regAddr == `RSCS_OFS_CTRL);
	assign pulseWr = regWrStb && (regAddr == `RSCS_OFS_PULSE) &&
		(regWrData[`RSCS_PULSE_W-1:0] != {`RSCS_PULSE_W{1'b0}});
	assign msTick = pulseBusy_reg && (msCount_reg == MS_LAST);
	assign pulseDone = msTick && (pulseLeft_reg == {{(`RSCS_PULSE_W-1){1'b0}}, 1'b1});
	assign hotplugLevel = hotplugCmd_reg & ~pulseBusy_reg;

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hotplugCmd_reg <= `RSCS_RST_CTRL;
			pulseBusy_reg <= 1'b0;
			msCount_reg <= 18'h00000;
			pulseLeft_reg <= {`RSCS_PULSE_W{1'b0}};
			pulseLen_reg <= {`RSCS_PULSE_W{1'b0}};
			hotplugPin <= HPD_LOW;
		end else begin
			if (ctrlWr) begin
				hotplugCmd_reg <= regWrData[`RSCS_CTRL_HOTPLUG];
			end
			if (pulseWr) begin
				pulseBusy_reg <= 1'b1;
				msCount_reg <= 18'h00000;
				pulseLeft_reg <= regWrData[`RSCS_PULSE_W-1:0];
				pulseLen_reg <= regWrData[`RSCS_PULSE_W-1:0];
			end else if (pulseBusy_reg) begin
				msCount_reg <= msTick ? 18'h00000 : msCount_reg + 18'h00001;
				if (msTick) begin
					pulseLeft_reg <= pulseLeft_reg - {{(`RSCS_PULSE_W-1){1'b0}}, 1'b1};
				end
				if (pulseDone) begin
					pulseBusy_reg <= 1'b0;
				end
			end
			hotplugPin <= hotplugLevel ^ HPD_LOW;
		end
	end

	// ------------------------------------------------------------------------
	// Interrupt status and masks
	// ------------------------------------------------------------------------
	reg cablePrev_reg;
	reg linkPrev_reg;
	reg videoPrev_reg;
	reg [`RSCS_EV_W-1:0] evStatus_reg;
	reg [`RSCS_EV_W-1:0] evMask_reg;
	reg [`RSCS_PROT_W-1:0] protStatus_reg;
	reg [`RSCS_PROT_W-1:0] protMask_reg;
	wire [`RSCS_EV_W-1:0] evSet;
	wire [`RSCS_PROT_W-1:0] protSet;
	wire evRd;
	wire protRd;

	assign evSet[`RSCS_EV_CABLE] = cableDetected ^ cablePrev_reg;
	assign evSet[`RSCS_EV_LINK_READY] = linkReady_reg ^ linkPrev_reg;
	assign evSet[`RSCS_EV_VIDEO_READY] = videoReady_reg ^ videoPrev_reg;
	assign evSet[`RSCS_EV_PULSE_DONE] = pulseDone;
	assign protSet[`RSCS_PROT_ENGINE] = protEngineEvent;
	assign protSet[`RSCS_PROT_TIMER] = protTimerEvent;
	assign evRd = regRdStb && (regAddr == `RSCS_OFS_IRQ_STATUS);
	assign protRd = regRdStb && (regAddr == `RSCS_OFS_PROT_STATUS);

	// A read clears the sticky bits, but an event in the same cycle survives.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cablePrev_reg <= 1'b0;
			linkPrev_reg <= 1'b0;
			videoPrev_reg <= 1'b0;
			evStatus_reg <= `RSCS_RST_EV;
			evMask_reg <= `RSCS_RST_EV;
			protStatus_reg <= `RSCS_RST_PROT;
			protMask_reg <= `RSCS_RST_PROT;
		end else begin
			cablePrev_reg <= cableDetected;
			linkPrev_reg <= linkReady_reg;
			videoPrev_reg <= videoReady_reg;
			evStatus_reg <= (evRd ? {`RSCS_EV_W{1'b0}} : evStatus_reg) | evSet;
			if (PROTECTION_PRESENT != 0) begin
				protStatus_reg <= (protRd ? {`RSCS_PROT_W{1'b0}} : protStatus_reg) | protSet;
			end
			if (regWrStb && (regAddr == `RSCS_OFS_IRQ_MASK)) begin
				evMask_reg <= regWrData[`RSCS_EV_W-1:0];
			end
			if (regWrStb && (regAddr == `RSCS_OFS_PROT_MASK)) begin
				protMask_reg <= regWrData[`RSCS_PROT_W-1:0];
			end
		end
	end

	assign irq = |(evStatus_reg & evMask_reg);
	assign protection_engine_interrupt = (PROTECTION_PRESENT != 0) &&
		protStatus_reg[`RSCS_PROT_ENGINE] && protMask_reg[`RSCS_PROT_ENGINE];
	assign protection_timer_interrupt = (PROTECTION_PRESENT != 0) &&
		protStatus_reg[`RSCS_PROT_TIMER] && protMask_reg[`RSCS_PROT_TIMER];

	// ------------------------------------------------------------------------
	// Register read port
	// ------------------------------------------------------------------------
	reg [`RSCS_DATA_W-1:0] rdValue;

	always @* begin
		rdValue = {`RSCS_DATA_W{1'b0}};
		case (regAddr)
			`RSCS_OFS_CTRL: begin
				rdValue[`RSCS_CTRL_HOTPLUG] = hotplugCmd_reg;
			end
			`RSCS_OFS_PULSE: begin
				rdValue[`RSCS_PULSE_W-1:0] = pulseLeft_reg;
			end
			`RSCS_OFS_STATE: begin
				rdValue[`RSCS_ST_CABLE] = cableDetected;
				rdValue[`RSCS_ST_LINK_READY] = linkReady_reg;
				rdValue[`RSCS_ST_VIDEO_READY] = videoReady_reg;
				rdValue[`RSCS_ST_PULSE_BUSY] = pulseBusy_reg;
				rdValue[`RSCS_ST_HOTPLUG] = hotplugLevel;
				// Classifies the last pulse: authentication restart or presence notice.
				rdValue[`RSCS_ST_PULSE_SHORT] = (pulseLen_reg >= SHORT_MIN) &&
					(pulseLen_reg <= SHORT_MAX);
				rdValue[`RSCS_ST_PULSE_LONG] = pulseLen_reg > LONG_MS;
			end
			`RSCS_OFS_IRQ_STATUS: begin
				rdValue[`RSCS_EV_W-1:0] = evStatus_reg;
			end
			`RSCS_OFS_IRQ_MASK: begin
				rdValue[`RSCS_EV_W-1:0] = evMask_reg;
			end
			`RSCS_OFS_PROT_STATUS: begin
				rdValue[`RSCS_PROT_W-1:0] = protStatus_reg;
			end
			`RSCS_OFS_PROT_MASK: begin
				rdValue[`RSCS_PROT_W-1:0] = protMask_reg;
			end
			default: begin
				rdValue = {`RSCS_DATA_W{1'b0}};
			end
		endcase
	end

	// Read data stand for exactly the cycle after the strobe.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			regRdData <= {`RSCS_DATA_W{1'b0}};
		end else begin
			regRdData <= regRdStb ? rdValue : {`RSCS_DATA_W{1'b0}};
		end
	end

endmodule

// >>> hdl/rscs_consts.vh
/*
 * Constants of the receiver sideband control block: register offsets,
 * field positions, reset values and timing figures.
 * Assumes it is included by bare name from the design files; definitions only.
 */
`ifndef RSCS_CONSTS_VH
`define RSCS_CONSTS_VH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define RSCS_CLK_PERIOD_NS 4
`define RSCS_MS_NS 1000000
`define RSCS_PULSE_SHORT_MIN_MS 16'h0064
`define RSCS_PULSE_SHORT_MAX_MS 16'h01F4
`define RSCS_PULSE_LONG_MS 16'h03E8

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define RSCS_ADDR_W 8
`define RSCS_DATA_W 32
`define RSCS_OFS_CTRL 8'h00
`define RSCS_OFS_PULSE 8'h04
`define RSCS_OFS_STATE 8'h08
`define RSCS_OFS_IRQ_STATUS 8'h0C
`define RSCS_OFS_IRQ_MASK 8'h10
`define RSCS_OFS_PROT_STATUS 8'h14
`define RSCS_OFS_PROT_MASK 8'h18

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RSCS_CTRL_HOTPLUG 0
`define RSCS_PULSE_W 16
`define RSCS_ST_CABLE 0
`define RSCS_ST_LINK_READY 1
`define RSCS_ST_VIDEO_READY 2
`define RSCS_ST_PULSE_BUSY 3
`define RSCS_ST_HOTPLUG 4
`define RSCS_ST_PULSE_SHORT 5
`define RSCS_ST_PULSE_LONG 6
`define RSCS_EV_CABLE 0
`define RSCS_EV_LINK_READY 1
`define RSCS_EV_VIDEO_READY 2
`define RSCS_EV_PULSE_DONE 3
`define RSCS_EV_W 4
`define RSCS_PROT_ENGINE 0
`define RSCS_PROT_TIMER 1
`define RSCS_PROT_W 2
`define RSCS_SB_LINK_READY 0
`define RSCS_SB_VIDEO_READY 1
`define RSCS_SB_W 2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RSCS_RST_CTRL 1'h0
`define RSCS_RST_EV 4'h0
`define RSCS_RST_PROT 2'h0

`endif

// >>> hdl/rscs_sync3.v
/*
 * Three-flop input filter with asynchronous reset to a constant.
 * Assumes d may change at any time relative to clk; q follows only once
 * the second and third stages agree.  Also used as a reset synchroniser
 * with d tied high.
 */
`timescale 1ns/1ps

module rscs_sync3 #(
	parameter W = 1,
	parameter [W-1:0] RESET_VAL = {W{1'b0}}
) (
	input wire clk,
	input wire nrst,
	input wire [W-1:0] d,
	output reg [W-1:0] q
);

	reg [W-1:0] stage1_reg;
	reg [W-1:0] stage2_reg;
	reg [W-1:0] stage3_reg;
	wire [W-1:0] agree;

	// Stage one feeds only stage two, so metastability never reaches logic.
	assign agree = ~(stage2_reg ^ stage3_reg);

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stage1_reg <= RESET_VAL;
			stage2_reg <= RESET_VAL;
			stage3_reg <= RESET_VAL;
			q <= RESET_VAL;
		end else begin
			stage1_reg <= d;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
			q <= (stage3_reg & agree) | (q & ~agree);
		end
	end

endmodule

// >>> test/rscs_sideband_ctrl_asserts.sv
/* Concurrent checks on the ports of the sideband control block.
 * Assumes every clock runs during and after the control reset. */
`timescale 1ns/1ps
`include "rscs_consts.vh"
module rscs_sideband_ctrl_asserts #(
	parameter HPD_ACTIVE_LOW = 0
) (
	input wire clk,
	input wire nrst,
	input wire pixelClk,
	input wire videoStreamClk,
	input wire videoStreamRstN,
	input wire audioStreamClk,
	input wire audioStreamRstN,
	input wire [`RSCS_ADDR_W-1:0] regAddr,
	input wire [`RSCS_DATA_W-1:0] regWrData,
	input wire regWrStb,
	input wire regRdStb,
	input wire hotplugPin,
	input wire videoInterlaced,
	input wire videoFieldOdd,
	input wire fieldId,
	input wire protEngineEvent,
	input wire irq,
	input wire protection_engine_interrupt,
	input wire pixelReset,
	input wire videoStreamReset,
	input wire audioStreamReset
);
	localparam bit RelLvl = HPD_ACTIVE_LOW != 0;
	// ------------------------------------------------------------------
	// Hot-plug pin, reset outputs and interrupts
	// ------------------------------------------------------------------
	sequence pulse_start_s;
		regWrStb && regAddr == `RSCS_OFS_PULSE && regWrData[15:0] != 16'h0000;
	endsequence
	sequence pin_released_s;
		(hotplugPin == RelLvl) [*2];
	endsequence
	pulse_low_a: assert property (@(posedge clk) disable iff (!nrst)
		pulse_start_s |-> ##3 pin_released_s) else $error("pulse did not release pin");
	hp_release_a: assert property (@(posedge clk) disable iff (!nrst)
		regWrStb && regAddr == `RSCS_OFS_CTRL && !regWrData[0] |-> ##2 hotplugPin == RelLvl)
		else $error("pin not released");
	rst_outs_a: assert property (@(posedge clk) disable iff (!nrst)
		$rose(nrst) |-> pixelReset && videoStreamReset && audioStreamReset && !irq)
		else $error("outputs not reset");
	prot_cause_a: assert property (@(posedge clk) disable iff (!nrst)
		$rose(protection_engine_interrupt) |-> $past(protEngineEvent) || $past(regWrStb))
		else $error("engine interrupt without cause");
	irq_fall_a: assert property (@(posedge clk) disable iff (!nrst)
		$fell(irq) |-> $past(regRdStb) || $past(regRdStb, 2) || $past(regWrStb)
		|| $past(regWrStb, 2)) else $error("interrupt dropped without access");
	// ------------------------------------------------------------------
	// Field identity and domain resets
	// ------------------------------------------------------------------
	field_low_a: assert property (@(posedge videoStreamClk)
		disable iff (!nrst || !videoStreamRstN)
		(!(videoInterlaced && videoFieldOdd)) [*8] |=> !fieldId) else $error("field high");
	field_odd_a: assert property (@(posedge videoStreamClk)
		disable iff (!nrst || !videoStreamRstN)
		(videoInterlaced && videoFieldOdd) [*8] |=> fieldId) else $error("field low");
	vid_rst_force_a: assert property (@(posedge videoStreamClk) disable iff (!nrst)
		!videoStreamRstN |-> videoStreamReset) else $error("video reset not forced");
	aud_rst_force_a: assert property (@(posedge audioStreamClk) disable iff (!nrst)
		!audioStreamRstN |-> audioStreamReset) else $error("audio reset not forced");
	aud_rst_free_a: assert property (@(posedge audioStreamClk) disable iff (!nrst)
		audioStreamRstN [*6] |-> !audioStreamReset) else $error("audio reset stuck");
	pix_rst_free_a: assert property (@(posedge pixelClk) disable iff (!nrst)
		nrst [*6] |-> !pixelReset) else $error("pixel reset stuck");
endmodule

bind rscs_sideband_ctrl rscs_sideband_ctrl_asserts #(.HPD_ACTIVE_LOW(HPD_ACTIVE_LOW))
	rscs_sideband_ctrl_asserts_inst (.clk, .nrst, .pixelClk, .videoStreamClk,
	.videoStreamRstN, .audioStreamClk, .audioStreamRstN, .regAddr, .regWrData, .regWrStb,
	.regRdStb, .hotplugPin, .videoInterlaced, .videoFieldOdd, .fieldId, .protEngineEvent,
	.irq, .protection_engine_interrupt, .pixelReset, .videoStreamReset, .audioStreamReset);

// >>> test/rscs_phy_model.sv
/* Far-side model: cable pin of the source and sideband status of the PHY side.
 * Assumes the bench sets the commanded levels between clock edges. */
`timescale 1ns/1ps
module rscs_phy_model #(
	parameter CABLE_ACTIVE_LOW = 0
) (
	input wire clk,
	input wire nrst,
	input wire cableOn,
	input wire linkReady,
	input wire videoReady,
	input wire statusOn,
	output reg cableDetectPin,
	output reg [1:0] sideband_status_word,
	output reg sideband_status_valid
);
	// An unqualified word toggles, so a stale value can never pass for status.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cableDetectPin <= CABLE_ACTIVE_LOW != 0;
			sideband_status_word <= 2'h0;
			sideband_status_valid <= 1'h0;
		end else begin
			cableDetectPin <= cableOn ^ (CABLE_ACTIVE_LOW != 0);
			sideband_status_valid <= statusOn;
			if (statusOn)
				sideband_status_word <= {videoReady, linkReady};
			else
				sideband_status_word <= ~sideband_status_word;
		end
	end
endmodule

// >>> test/tb_rscs_sideband_ctrl.sv
/* Self-checking bench of the sideband control block with the far-side model.
 * Assumes the design and checker files are compiled before it. */
`timescale 1ns/1ps
`include "rscs_consts.vh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
	$display("[ERR] %s expected %h seen %h", nm, e, g); end end
module tb_rscs_sideband_ctrl;
	reg clk = 0, nrst = 0, pixelClk = 0, videoStreamClk = 0, audioStreamClk = 0;
	reg videoStreamRstN = 1, audioStreamRstN = 1, regWrStb = 0, regRdStb = 0;
	reg [7:0] regAddr = 8'h00;
	reg [31:0] regWrData = 32'h0, rdv, rdvLo;
	reg videoInterlaced = 0, videoFieldOdd = 0, protEngineEvent = 0, protTimerEvent = 0;
	reg cableOn = 0, linkReady = 0, videoReady = 0, statusOn = 0;
	wire [31:0] regRdData;
	wire [1:0] sideband_status_word;
	wire hotplugPin, cableDetectPin, sideband_status_valid, fieldId, irq;
	wire protection_engine_interrupt, protection_timer_interrupt;
	wire pixelReset, videoStreamReset, audioStreamReset;
	int fails = 0, n_checks = 0;
	int len[3] = '{1, 100, 1001};
	bit [2:0] fld[3] = '{3'h7, 3'h4, 3'h2};
	always #2 clk = ~clk;
	always #3 pixelClk = ~pixelClk;
	always #2.5 videoStreamClk = ~videoStreamClk;
	always #3.5 audioStreamClk = ~audioStreamClk;
	rscs_sideband_ctrl #(.MS_CYCLES(4)) rscs_sideband_ctrl_inst (.clk, .nrst, .pixelClk,
		.videoStreamClk, .videoStreamRstN, .audioStreamClk, .audioStreamRstN, .regAddr,
		.regWrData, .regWrStb, .regRdStb, .regRdData, .hotplugPin, .cableDetectPin,
		.sideband_status_word, .sideband_status_valid, .videoInterlaced, .videoFieldOdd,
		.fieldId, .protEngineEvent, .protTimerEvent, .irq, .protection_engine_interrupt,
		.protection_timer_interrupt, .pixelReset, .videoStreamReset, .audioStreamReset);
	rscs_phy_model rscs_phy_model_inst (.clk, .nrst, .cableOn, .linkReady, .videoReady,
		.statusOn, .cableDetectPin, .sideband_status_word, .sideband_status_valid);
	wire [31:0] regRdDataLo;
	wire [1:0] sbWordLo;
	wire hotplugPinLo, cablePinLo, sbValidLo, fieldIdLo;
	// Second build with both pins inverted and native video, sharing bus and stimulus.
	rscs_sideband_ctrl #(.HPD_ACTIVE_LOW(1), .CABLE_ACTIVE_LOW(1), .STREAM_VIDEO(0),
		.MS_CYCLES(4)) rscs_sideband_ctrl_low_inst (.clk, .nrst, .pixelClk, .videoStreamClk,
		.videoStreamRstN, .audioStreamClk, .audioStreamRstN, .regAddr, .regWrData, .regWrStb,
		.regRdStb, .regRdData(regRdDataLo), .hotplugPin(hotplugPinLo),
		.cableDetectPin(cablePinLo), .sideband_status_word(sbWordLo),
		.sideband_status_valid(sbValidLo), .videoInterlaced, .videoFieldOdd,
		.fieldId(fieldIdLo), .protEngineEvent, .protTimerEvent, .irq(),
		.protection_engine_interrupt(), .protection_timer_interrupt(), .pixelReset(),
		.videoStreamReset(), .audioStreamReset());
	rscs_phy_model #(.CABLE_ACTIVE_LOW(1)) rscs_phy_model_low_inst (.clk, .nrst, .cableOn,
		.linkReady, .videoReady, .statusOn, .cableDetectPin(cablePinLo),
		.sideband_status_word(sbWordLo), .sideband_status_valid(sbValidLo));
	// ------------------------------------------------------------------
	// Bus cycles
	// ------------------------------------------------------------------
	task wr(input [7:0] a, input [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1;
		@(posedge clk);
		regWrStb <= 0;
	endtask
	task rd(input [7:0] a);
		@(posedge clk);
		regAddr <= a;
		regRdStb <= 1;
		@(posedge clk);
		regRdStb <= 0;
		#1;
		rdv = regRdData;
		rdvLo = regRdDataLo;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task t_reset;
		`CHK("hotplug", 1'h0, hotplugPin)
		`CHK("hotplug low", 1'h1, hotplugPinLo)
		`CHK("irq", 1'h0, irq)
		rd(`RSCS_OFS_CTRL);
		`CHK("ctrl", 32'h0, rdv)
		rd(`RSCS_OFS_IRQ_MASK);
		`CHK("mask", 32'h0, rdv)
		rd(8'h1C);
		`CHK("unmapped", 32'h0, rdv)
		rd(`RSCS_OFS_IRQ_STATUS);
		`CHK("no event", 32'h0, rdv)
		`CHK("no event low", 32'h0, rdvLo)
	endtask
	task t_hotplug;
		wr(`RSCS_OFS_CTRL, 32'h1);
		cyc(3);
		`CHK("hp on", 1'h1, hotplugPin)
		`CHK("hp on low", 1'h0, hotplugPinLo)
		rd(`RSCS_OFS_STATE);
		`CHK("hp state", 1'h1, rdv[`RSCS_ST_HOTPLUG])
		wr(`RSCS_OFS_CTRL, 32'h0);
		cyc(3);
		`CHK("hp off", 1'h0, hotplugPin)
		`CHK("hp off low", 1'h1, hotplugPinLo)
		wr(`RSCS_OFS_CTRL, 32'h1);
		wr(`RSCS_OFS_PULSE, 32'h0);
		cyc(3);
		`CHK("hp held", 1'h1, hotplugPin)
	endtask
	task t_pulse;
		for (int i = 0; i < 3; i++) begin
			wr(`RSCS_OFS_PULSE, 32'(len[i]));
			cyc(3);
			`CHK("pulse low", 1'h0, hotplugPin)
			cyc(len[i] * 4 + 4);
			`CHK("pulse end", 1'h1, hotplugPin)
			rd(`RSCS_OFS_STATE);
			`CHK("short", len[i] >= 100 && len[i] <= 500, rdv[`RSCS_ST_PULSE_SHORT])
			`CHK("long", len[i] > 1000, rdv[`RSCS_ST_PULSE_LONG])
			rd(`RSCS_OFS_IRQ_STATUS);
			`CHK("pulse done", 4'h8, rdv[3:0])
		end
		rd(`RSCS_OFS_IRQ_STATUS);
		`CHK("read clear", 32'h0, rdv)
	endtask
	task t_side;
		cableOn <= 1;
		linkReady <= 1;
		statusOn <= 1;
		cyc(8);
		rd(`RSCS_OFS_STATE);
		`CHK("cable", 3'h3, rdv[2:0])
		`CHK("cable low", 3'h3, rdvLo[2:0])
		linkReady <= 0;
		videoReady <= 1;
		cyc(8);
		rd(`RSCS_OFS_STATE);
		`CHK("video", 2'h2, rdv[2:1])
		statusOn <= 0;
		linkReady <= 1;
		cyc(8);
		rd(`RSCS_OFS_STATE);
		`CHK("unqualified", 2'h2, rdv[2:1])
		rd(`RSCS_OFS_IRQ_STATUS);
		`CHK("events", 4'h7, rdv[3:0])
		`CHK("events low", 4'h7, rdvLo[3:0])
	endtask
	task t_irq;
		cableOn <= 0;
		cyc(8);
		`CHK("masked", 1'h0, irq)
		wr(`RSCS_OFS_IRQ_MASK, 32'h1);
		cyc(1);
		`CHK("unmasked", 1'h1, irq)
		rd(`RSCS_OFS_IRQ_STATUS);
		`CHK("cable event", 4'h1, rdv[3:0])
		`CHK("cable event low", 4'h1, rdvLo[3:0])
		cyc(1);
		`CHK("cleared", 1'h0, irq)
	endtask
	task t_prot;
		wr(`RSCS_OFS_PROT_MASK, 32'h3);
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			protEngineEvent <= (i == 0);
			protTimerEvent <= (i == 1);
			@(posedge clk);
			protEngineEvent <= 0;
			protTimerEvent <= 0;
			cyc(1);
			`CHK("prot irqs", 2'(1 << i), {protection_timer_interrupt, protection_engine_interrupt})
			rd(`RSCS_OFS_PROT_STATUS);
			`CHK("prot status", 2'(1 << i), rdv[1:0])
		end
		cyc(1);
		`CHK("prot clear", 2'h0, {protection_timer_interrupt, protection_engine_interrupt})
	endtask
	task t_field;
		for (int i = 0; i < 3; i++) begin
			@(posedge pixelClk);
			videoInterlaced <= fld[i][2];
			videoFieldOdd <= fld[i][1];
			cyc(12);
			`CHK("field", fld[i][0], fieldId)
			`CHK("field low", fld[i][0], fieldIdLo)
		end
	endtask
	task t_resets;
		`CHK("pix rst", 1'h0, pixelReset)
		@(posedge videoStreamClk);
		videoStreamRstN <= 0;
		cyc(4);
		`CHK("vid rst", 3'h4, {videoStreamReset, audioStreamReset, pixelReset})
		`CHK("hp kept", 1'h1, hotplugPin)
		@(posedge videoStreamClk);
		videoStreamRstN <= 1;
		cyc(8);
		@(posedge audioStreamClk);
		audioStreamRstN <= 0;
		cyc(4);
		`CHK("aud rst", 3'h2, {videoStreamReset, audioStreamReset, pixelReset})
		@(posedge audioStreamClk);
		audioStreamRstN <= 1;
		cyc(10);
		`CHK("rst free", 3'h0, {videoStreamReset, audioStreamReset, pixelReset})
	endtask
	task results;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#100000;
		fails++;
		results;
	end
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1;
		cyc(2);
		t_reset;
		t_hotplug;
		t_pulse;
		t_side;
		t_irq;
		t_prot;
		t_field;
		t_resets;
		@(posedge clk);
		nrst <= 0;
		repeat (12) @(posedge clk);
		nrst <= 1;
		cyc(2);
		t_reset;
		results;
	end
endmodule
